// *** shared/dtmr_pkg.sv ***
package dtmr_pkg;

	// ==========================================================
	// bus geometry and register indices (byte address = 4 * index)
	localparam int         AW            = 10;
	localparam logic [9:0] IDX_LOW_CNT   = 10'h106;
	localparam logic [9:0] IDX_HOLD      = 10'h108;
	localparam logic [9:0] IDX_HIGH_CNT  = 10'h10A;
	localparam logic [9:0] IDX_LOW_PER   = 10'h10C;
	localparam logic [9:0] IDX_HIGH_PER  = 10'h10E;
	localparam logic [9:0] IDX_LOW_CTL   = 10'h110;
	localparam logic [9:0] IDX_HIGH_CTL  = 10'h112;
	localparam logic [9:0] IDX_IRQ_STAT  = 10'h114;
	localparam logic [9:0] IDX_IRQ_MASK  = 10'h116;

	// ==========================================================
	// reset values and writable bits
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [15:0] RST_PERIOD   = 16'hFFFF;
	localparam logic [15:0] RST_CTL      = 16'h0000;
	localparam logic [15:0] CTL_MASK_LO  = 16'hA07A;
	localparam logic [15:0] CTL_MASK_HI  = 16'hA072;
	localparam logic [1:0]  RST_IRQ      = 2'h0;
	localparam int          STAT_LOW     = 0;
	localparam int          STAT_HIGH    = 1;

	// ==========================================================
	// prescaler terminal counts
	localparam logic [7:0] PS_TERM_1     = 8'h00;
	localparam logic [7:0] PS_TERM_8     = 8'h07;
	localparam logic [7:0] PS_TERM_64    = 8'h3F;
	localparam logic [7:0] PS_TERM_256   = 8'hFF;
	localparam logic [7:0] RST_PS        = 8'h00;

	typedef enum logic [1:0] {
		DTMR_PS_1   = 2'h0,
		DTMR_PS_8   = 2'h1,
		DTMR_PS_64  = 2'h2,
		DTMR_PS_256 = 2'h3
	} dtmr_ps_t;

	typedef enum logic [1:0] {
		DTMR_BUS_IDLE = 2'b01,
		DTMR_BUS_ACK  = 2'b10
	} dtmr_bus_t;

	typedef struct packed {
		logic       counter_on;
		logic       rsv14;
		logic       stop_in_idle;
		logic [5:0] rsv12_7;
		logic       gated_accumulate_enable;
		dtmr_ps_t   prescale_select;
		logic       cascade_select;
		logic       rsv2;
		logic       count_source_select;
		logic       rsv0;
	} dtmr_ctl_t;

	typedef struct packed {
		logic [15:0] high_word_count;
		logic [15:0] low_word_count;
	} dtmr_tbase_t;

	function automatic logic [7:0] dtmr_ps_term(input dtmr_ps_t s);
		unique case (s)
			DTMR_PS_1:   dtmr_ps_term = PS_TERM_1;
			DTMR_PS_8:   dtmr_ps_term = PS_TERM_8;
			DTMR_PS_64:  dtmr_ps_term = PS_TERM_64;
			DTMR_PS_256: dtmr_ps_term = PS_TERM_256;
		endcase
	endfunction

endpackage

// *** hw/dtmr_sync.sv ***
`timescale 1ns/10ps
module dtmr_sync (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic ce,
	// pin and conditioned view
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic ff1_reg, ff2_reg, prev_reg;
	logic ff1_next, ff2_next, prev_next;

	always_comb begin
		ff1_next  = pin;
		ff2_next  = ff1_reg;
		prev_next = ff2_reg;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ff1_reg  <= 1'b0;
			ff2_reg  <= 1'b0;
			prev_reg <= 1'b0;
		end else if (ce) begin
			ff1_reg  <= ff1_next;
			ff2_reg  <= ff2_next;
			prev_reg <= prev_next;
		end
	end

	assign level = ff2_reg;
	assign rise  = ff2_reg & ~prev_reg;
	assign fall  = ~ff2_reg & prev_reg;
endmodule

// *** hw/dtmr_presc.sv ***
`timescale 1ns/10ps
module dtmr_presc (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// control
	input  wire logic              run,
	input  wire logic              clr,
	input  wire dtmr_pkg::dtmr_ps_t sel,
	// ticks
	input  wire logic              tick_in,
	output logic                   tick_out
);
	import dtmr_pkg::*;

	logic [7:0] cnt_reg, cnt_next;

	assign tick_out = run & tick_in & (cnt_reg == dtmr_ps_term(sel));

	always_comb begin
		cnt_next = cnt_reg;
		if (clr)
			cnt_next = RST_PS;
		else if (tick_out)
			cnt_next = RST_PS;
		else if (run & tick_in)
			cnt_next = cnt_reg + 8'h01;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			cnt_reg <= RST_PS;
		else if (ce)
			cnt_reg <= cnt_next;
	end
endmodule

// *** hw/dtmr_top.sv ***
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module dtmr_top (
	// clock, reset, enable
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	// avalon-mm slave
	input  wire logic [dtmr_pkg::AW-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [3:0]             avs_byteenable,
	input  wire logic [31:0]            avs_writedata,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	// pins and cpu state
	input  wire logic                   external_count_gate_input,
	input  wire logic                   high_external_count_input,
	input  wire logic                   cpu_idle,
	// time base, trigger, interrupt
	output dtmr_pkg::dtmr_tbase_t       time_base,
	output logic                        adc_trigger,
	output logic                        irq
);
	import dtmr_pkg::*;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ==========================================================
	// state
	dtmr_bus_t   bus_reg, bus_next;
	logic [15:0] lo_cnt_reg, lo_cnt_next, hi_cnt_reg, hi_cnt_next;
	logic [15:0] hold_reg, hold_next, lo_per_reg, lo_per_next;
	logic [15:0] hi_per_reg, hi_per_next;
	dtmr_ctl_t   lo_ctl_reg, lo_ctl_next, hi_ctl_reg, hi_ctl_next;
	logic [1:0]  stat_reg, stat_next, mask_reg, mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        adc_reg, adc_next, lo_tick_reg, lo_tick_next;

	// ==========================================================
	// bus decode
	logic acc, wr, rd;
	logic wr_lo_cnt, wr_hi_cnt, wr_hold, wr_lo_ctl, wr_hi_ctl;
	logic rd_lo_cnt, rd_stat;

	assign acc       = ce & (bus_reg == DTMR_BUS_IDLE) & (avs_read | avs_write);
	assign wr        = acc & avs_write;
	assign rd        = acc & avs_read;
	assign wr_lo_cnt = wr & (avs_address == IDX_LOW_CNT);
	assign wr_hi_cnt = wr & (avs_address == IDX_HIGH_CNT);
	assign wr_hold   = wr & (avs_address == IDX_HOLD);
	assign wr_lo_ctl = wr & (avs_address == IDX_LOW_CTL);
	assign wr_hi_ctl = wr & (avs_address == IDX_HIGH_CTL);
	assign rd_lo_cnt = rd & (avs_address == IDX_LOW_CNT);
	assign rd_stat   = rd & (avs_address == IDX_IRQ_STAT);

	assign avs_waitrequest = (avs_read | avs_write) & (bus_reg != DTMR_BUS_ACK);
	assign avs_readdata    = rdata_reg;

	// ==========================================================
	// pin conditioning and tick sources
	logic lo_lvl, lo_rise, lo_fall, hi_rise;
	logic t32, lo_run, hi_run, lo_gated, lo_src, hi_src;
	logic lo_ps_out, hi_ps_out, lo_tick, hi_tick;

	dtmr_sync u_sync_lo (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.pin   (external_count_gate_input),
		.level (lo_lvl),
		.rise  (lo_rise),
		.fall  (lo_fall)
	);

	dtmr_sync u_sync_hi (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.pin   (high_external_count_input),
		.level (),
		.rise  (hi_rise),
		.fall  ()
	);

	assign t32      = lo_ctl_reg.cascade_select;
	assign lo_run   = lo_ctl_reg.counter_on
	                & ~(cpu_idle & lo_ctl_reg.stop_in_idle);
	assign hi_run   = ~t32 & hi_ctl_reg.counter_on
	                & ~(cpu_idle & hi_ctl_reg.stop_in_idle);
	assign lo_gated = lo_ctl_reg.gated_accumulate_enable
	                & ~lo_ctl_reg.count_source_select;
	// instruction cycle, gate level, or synchronised external rise
	assign lo_src   = lo_ctl_reg.count_source_select ? lo_rise
	                : (lo_gated ? lo_lvl : 1'b1);
	// upper half has no gate mode
	assign hi_src   = hi_ctl_reg.count_source_select ? hi_rise : 1'b1;

	dtmr_presc u_presc_lo (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.run      (lo_run),
		.clr      ((wr_lo_cnt | wr_lo_ctl) & lo_ctl_reg.counter_on),
		.sel      (lo_ctl_reg.prescale_select),
		.tick_in  (lo_src),
		.tick_out (lo_ps_out)
	);

	dtmr_presc u_presc_hi (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.run      (hi_run),
		.clr      ((wr_hi_cnt | wr_hi_ctl) & hi_ctl_reg.counter_on),
		.sel      (hi_ctl_reg.prescale_select),
		.tick_in  (hi_src),
		.tick_out (hi_ps_out)
	);

	assign lo_tick_next = lo_ps_out;
	assign lo_tick      = lo_tick_reg & lo_run;
	assign hi_tick      = hi_ps_out;

	// ==========================================================
	// match and events
	logic match32, match_lo, match_hi, wrap32, wrap_lo, wrap_hi;
	logic gate_fall;

	assign match32   = {hi_cnt_reg, lo_cnt_reg} == {hi_per_reg, lo_per_reg};
	assign match_lo  = lo_cnt_reg == lo_per_reg;
	assign match_hi  = hi_cnt_reg == hi_per_reg;
	assign wrap32    = t32 & lo_tick & match32;
	assign wrap_lo   = ~t32 & lo_tick & match_lo;
	assign wrap_hi   = hi_tick & match_hi;
	assign gate_fall = lo_gated & lo_ctl_reg.counter_on & lo_fall;

	// ==========================================================
	// next state
	always_comb begin
		lo_cnt_next = lo_cnt_reg;
		hi_cnt_next = hi_cnt_reg;
		hold_next   = hold_reg;
		lo_per_next = lo_per_reg;
		hi_per_next = hi_per_reg;
		lo_ctl_next = lo_ctl_reg;
		hi_ctl_next = hi_ctl_reg;
		mask_next   = mask_reg;
		rdata_next  = rdata_reg;
		adc_next    = wrap32 | wrap_hi;
		bus_next    = bus_reg;

		unique case (bus_reg)
			DTMR_BUS_IDLE: if (avs_read | avs_write) bus_next = DTMR_BUS_ACK;
			DTMR_BUS_ACK:  bus_next = DTMR_BUS_IDLE;
			default:       bus_next = DTMR_BUS_IDLE;
		endcase

		if (t32) begin
			if (lo_tick)
				{hi_cnt_next, lo_cnt_next} = wrap32 ? 32'h00000000
					: {hi_cnt_reg, lo_cnt_reg} + 32'h00000001;
		end else begin
			if (lo_tick)
				lo_cnt_next = match_lo ? RST_COUNT : lo_cnt_reg + 16'h0001;
			if (hi_tick)
				hi_cnt_next = match_hi ? RST_COUNT : hi_cnt_reg + 16'h0001;
		end

		// direct count writes win over counting
		if (wr_lo_cnt) begin
			lo_cnt_next = merge(lo_cnt_reg, avs_writedata, avs_byteenable);
			if (t32)
				hi_cnt_next = hold_reg;
		end
		if (wr_hi_cnt)
			hi_cnt_next = merge(hi_cnt_reg, avs_writedata, avs_byteenable);
		if (wr_hold)
			hold_next = merge(hold_reg, avs_writedata, avs_byteenable);
		else if (rd_lo_cnt)
			hold_next = hi_cnt_reg;
		if (wr & (avs_address == IDX_LOW_PER))
			lo_per_next = merge(lo_per_reg, avs_writedata, avs_byteenable);
		if (wr & (avs_address == IDX_HIGH_PER))
			hi_per_next = merge(hi_per_reg, avs_writedata, avs_byteenable);
		// control writes load no timer count but clear the prescaler count while counter_on is set
		if (wr_lo_ctl)
			lo_ctl_next = dtmr_ctl_t'(merge(lo_ctl_reg, avs_writedata,
				avs_byteenable) & CTL_MASK_LO);
		if (wr_hi_ctl)
			hi_ctl_next = dtmr_ctl_t'(merge(hi_ctl_reg, avs_writedata,
				avs_byteenable) & CTL_MASK_HI);
		if (wr & (avs_address == IDX_IRQ_MASK))
			mask_next = avs_writedata[1:0];

		if (rd) begin
			unique case (avs_address)
				IDX_LOW_CNT:  rdata_next = {16'h0000, lo_cnt_reg};
				IDX_HOLD:     rdata_next = {16'h0000, hold_reg};
				IDX_HIGH_CNT: rdata_next = {16'h0000, hi_cnt_reg};
				IDX_LOW_PER:  rdata_next = {16'h0000, lo_per_reg};
				IDX_HIGH_PER: rdata_next = {16'h0000, hi_per_reg};
				IDX_LOW_CTL:  rdata_next = {16'h0000, lo_ctl_reg};
				IDX_HIGH_CTL: rdata_next = {16'h0000, hi_ctl_reg};
				IDX_IRQ_STAT: rdata_next = {30'h00000000, stat_reg};
				IDX_IRQ_MASK: rdata_next = {30'h00000000, mask_reg};
				default:      rdata_next = 32'h00000000;
			endcase
		end

		// read clears, a new event in the same cycle survives
		stat_next = rd_stat ? 2'h0 : stat_reg;
		stat_next[STAT_LOW]  = stat_next[STAT_LOW]
			| wrap_lo | (~t32 & gate_fall);
		stat_next[STAT_HIGH] = stat_next[STAT_HIGH]
			| wrap32 | wrap_hi | (t32 & gate_fall);
	end

	// ==========================================================
	// registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bus_reg     <= DTMR_BUS_IDLE;
			lo_cnt_reg  <= RST_COUNT;
			hi_cnt_reg  <= RST_COUNT;
			hold_reg    <= RST_COUNT;
			lo_per_reg  <= RST_PERIOD;
			hi_per_reg  <= RST_PERIOD;
			lo_ctl_reg  <= RST_CTL;
			hi_ctl_reg  <= RST_CTL;
			stat_reg    <= RST_IRQ;
			mask_reg    <= RST_IRQ;
			rdata_reg   <= 32'h00000000;
			adc_reg     <= 1'b0;
			lo_tick_reg <= 1'b0;
		end else if (ce) begin
			bus_reg     <= bus_next;
			lo_cnt_reg  <= lo_cnt_next;
			hi_cnt_reg  <= hi_cnt_next;
			hold_reg    <= hold_next;
			lo_per_reg  <= lo_per_next;
			hi_per_reg  <= hi_per_next;
			lo_ctl_reg  <= lo_ctl_next;
			hi_ctl_reg  <= hi_ctl_next;
			stat_reg    <= stat_next;
			mask_reg    <= mask_next;
			rdata_reg   <= rdata_next;
			adc_reg     <= adc_next;
			lo_tick_reg <= lo_tick_next;
		end
	end

	assign time_base   = {hi_cnt_reg, lo_cnt_reg};
	assign adc_trigger = adc_reg;
	assign irq         = |(stat_reg & mask_reg);

	// ==========================================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_wrap32;
		ce & wrap32 & ~wr_lo_cnt & ~wr_hi_cnt |=> time_base == 32'h00000000;
	endproperty
	a_wrap32: assert property (p_wrap32) else $error("no 32-bit wrap");

	property p_inc32;
		ce & t32 & lo_tick & ~match32 & ~wr_lo_cnt & ~wr_hi_cnt
			|=> time_base == $past(time_base) + 32'h00000001;
	endproperty
	a_inc32: assert property (p_inc32) else $error("bad 32-bit step");

	property p_hold;
		rd_lo_cnt |=> hold_reg == $past(hi_cnt_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("hold not latched");

	property p_wr32;
		wr_lo_cnt & t32 & ~wr_hi_cnt |=> hi_cnt_reg == $past(hold_reg);
	endproperty
	a_wr32: assert property (p_wr32) else $error("hold not moved");

	property p_ctlwr;
		ce & (wr_lo_ctl | wr_hi_ctl) & ~lo_tick & ~hi_tick
			|=> $stable(time_base);
	endproperty
	a_ctlwr: assert property (p_ctlwr) else $error("count changed");

	property p_idle;
		ce & cpu_idle & lo_ctl_reg.stop_in_idle & ~wr_lo_cnt
			|=> $stable(lo_cnt_reg);
	endproperty
	a_idle: assert property (p_idle) else $error("counted in idle");

	property p_adc;
		ce & (wrap32 | wrap_hi) |=> adc_trigger ##1 (!adc_trigger
			|| !$past(ce) || $past(ce & (wrap32 | wrap_hi)));
	endproperty
	a_adc: assert property (p_adc) else $error("no trigger pulse");

	property p_flag;
		ce & t32 & (wrap32 | gate_fall) |=> stat_reg[STAT_HIGH];
	endproperty
	a_flag: assert property (p_flag) else $error("flag not set");

	property p_wrap16;
		ce & wrap_lo & ~wr_lo_cnt |=> lo_cnt_reg == RST_COUNT;
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("no 16-bit wrap");

	property p_wait;
		(avs_read | avs_write) & ce & avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("slave stalled");

	c_wrap32:  cover property (ce & wrap32);
	c_wrap_hi: cover property (ce & wrap_hi);
	c_gate:    cover property (ce & gate_fall);
	c_wr32:    cover property (wr_hold ##[1:20] (wr_lo_cnt & t32));
endmodule

// *** test/dtmr_far_model.sv ***
`timescale 1ns/10ps
module dtmr_far_model (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// pin stimulus
	input  wire logic                  burst,
	input  wire logic                  gate_lvl,
	output logic                       ext_pin,
	output logic [15:0]                edges,
	// capture peripheral
	input  wire dtmr_pkg::dtmr_tbase_t time_base,
	input  wire logic                  capture,
	output logic [31:0]                captured
);
	import dtmr_pkg::*;
	logic [1:0] div;
	// ==========================================================
	// pin driver and time base capture
	// pin toggles every 4 cycles in a burst, else rests at the gate level
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div      <= 2'h0;
			ext_pin  <= 1'b0;
			edges    <= 16'h0000;
			captured <= 32'h0000_0000;
		end else begin
			div <= div + 2'h1;
			if (!burst)
				ext_pin <= gate_lvl;
			else if (div == 2'h3) begin
				ext_pin <= !ext_pin;
				if (!ext_pin)
					edges <= edges + 16'h0001;
			end
			if (capture)
				captured <= time_base;
		end
	end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	import dtmr_pkg::*;
	logic              mclk, rst_n, ce, avs_read, avs_write, avs_waitrequest;
	logic              cpu_idle, burst, gate_lvl, capture, ext_pin;
	logic              adc_trigger, irq;
	logic [AW-1:0]     avs_address;
	logic [31:0]       avs_writedata, avs_readdata, captured;
	logic [15:0]       edges;
	dtmr_tbase_t       time_base;
	int                err_count, tests_run;

	dtmr_top dtmr_top_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(4'hF),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.external_count_gate_input(ext_pin),
		.high_external_count_input(ext_pin), .cpu_idle(cpu_idle),
		.time_base(time_base), .adc_trigger(adc_trigger), .irq(irq));
	dtmr_far_model dtmr_far_model_inst (.mclk(mclk), .rst_n(rst_n),
		.burst(burst), .gate_lvl(gate_lvl), .ext_pin(ext_pin),
		.edges(edges), .time_base(time_base), .capture(capture),
		.captured(captured));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ==========================================================
	// compare, report and bus tasks
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic test_done;
		$display("mismatches %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [AW-1:0] a,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= !w;
		avs_writedata <= {16'h0000, wd};
		n = 0;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) begin
				err_count++;
				$display("ERROR waitrequest expected 0 seen 1");
				test_done;
			end
			@(posedge mclk);
		end
		rd = avs_readdata[15:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
		logic [15:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [AW-1:0] a, output logic [15:0] d);
		bus(1'b0, a, 16'h0000, d);
	endtask
	task automatic watch(input int n, input logic [31:0] lim, output logic wrp,
		output logic adc);
		logic [31:0] prev;
		prev = time_base;
		wrp = 1'b0;
		adc = 1'b0;
		repeat (n) begin
			@(posedge mclk);
			if (time_base > lim)
				chk("time_base bound", lim, time_base);
			if (time_base < prev)
				wrp = 1'b1;
			if (adc_trigger === 1'b1)
				adc = 1'b1;
			prev = time_base;
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic s_reset;
		logic [15:0] d;
		rd(IDX_LOW_PER, d);
		chk("low_period_value", RST_PERIOD, d);
		rd(IDX_HIGH_CTL, d);
		chk("high_half_control", RST_CTL, d);
		rd(10'h000, d);
		chk("unmapped", 32'h0, d);
		chk("time_base", 32'h0, time_base);
		chk1("irq", 1'b0, irq);
	endtask
	task automatic s_hold;
		logic [15:0] d;
		wr(IDX_LOW_CNT, 16'h1234);
		wr(IDX_HIGH_CNT, 16'h00AB);
		wr(IDX_LOW_CTL, 16'h0030);
		wr(IDX_HIGH_CTL, 16'h0030);
		rd(IDX_LOW_CNT, d);
		chk("low_word_count", 32'h1234, d);
		rd(IDX_HOLD, d);
		chk("upper_word_holding", 32'h00AB, d);
		wr(IDX_HOLD, 16'h0055);
		wr(IDX_LOW_CTL, 16'h0008);
		wr(IDX_LOW_CNT, 16'h0001);
		capture <= 1'b1;
		@(posedge mclk);
		capture <= 1'b0;
		@(posedge mclk);
		chk("captured", 32'h0055_0001, captured);
	endtask
	task automatic s_wrap16;
		logic [15:0] d;
		logic        w, a;
		wr(IDX_LOW_CTL, 16'h0000);
		wr(IDX_LOW_PER, 16'h0003);
		wr(IDX_LOW_CNT, 16'h0000);
		wr(IDX_IRQ_MASK, 16'h0001);
		rd(IDX_IRQ_STAT, d);
		wr(IDX_LOW_CTL, 16'h8000);
		watch(20, 32'h0055_0003, w, a);
		chk1("low wrap", 1'b1, w);
		chk1("adc on low match", 1'b0, a);
		chk1("irq", 1'b1, irq);
		wr(IDX_LOW_CTL, 16'h0000);
		rd(IDX_IRQ_STAT, d);
		chk("irq status", 32'h0001, d);
		rd(IDX_IRQ_STAT, d);
		chk("irq status cleared", 32'h0000, d);
		chk1("irq cleared", 1'b0, irq);
	endtask
	task automatic s_cascade;
		logic [15:0] d;
		logic        w, a;
		wr(IDX_LOW_CTL, 16'h0008);
		wr(IDX_HIGH_CTL, 16'h8000);
		wr(IDX_LOW_PER, 16'h0002);
		wr(IDX_HIGH_PER, 16'h0001);
		wr(IDX_HOLD, 16'h0001);
		wr(IDX_LOW_CNT, 16'h0000);
		wr(IDX_IRQ_MASK, 16'h0002);
		rd(IDX_IRQ_STAT, d);
		chk("time_base idle", 32'h0001_0000, time_base);
		wr(IDX_LOW_CTL, 16'h8008);
		watch(12, 32'h0001_0002, w, a);
		chk1("32-bit wrap", 1'b1, w);
		chk1("adc trigger", 1'b1, a);
		chk1("irq", 1'b1, irq);
		rd(IDX_IRQ_STAT, d);
		chk("irq status", 32'h0002, d);
		wr(IDX_LOW_CTL, 16'h0000);
		wr(IDX_HIGH_CTL, 16'h0000);
	endtask
	task automatic s_presc;
		logic [15:0] d;
		int          ex;
		wr(IDX_LOW_PER, 16'hFFFF);
		for (int i = 0; i < 4; i++) begin
			wr(IDX_LOW_CTL, 16'h0000);
			wr(IDX_LOW_CNT, 16'h0000);
			wr(IDX_LOW_CTL, 16'h8000 | (16'(i) << 4));
			repeat (512) @(posedge mclk);
			ex = 512 >> (i == 3 ? 8 : 3 * i);
			d = time_base.low_word_count;
			chk1("prescale count", 1'b1, d + 2 >= ex && d <= ex + 1);
		end
		wr(IDX_LOW_CTL, 16'h0000);
	endtask
	task automatic s_ext;
		logic [15:0] e0;
		logic [31:0] t;
		wr(IDX_LOW_CNT, 16'h0000);
		wr(IDX_HIGH_PER, 16'hFFFF);
		wr(IDX_HIGH_CNT, 16'h0000);
		wr(IDX_HIGH_CTL, 16'h8002);
		wr(IDX_LOW_CTL, 16'h8002);
		e0 = edges;
		burst <= 1'b1;
		repeat (60) @(posedge mclk);
		burst <= 1'b0;
		repeat (12) @(posedge mclk);
		chk("sync count", edges - e0, time_base.low_word_count);
		chk("high sync count", edges - e0, time_base.high_word_count);
		wr(IDX_HIGH_CTL, 16'h0000);
		wr(IDX_LOW_CTL, 16'hA002);
		cpu_idle <= 1'b1;
		burst    <= 1'b1;
		repeat (12) @(posedge mclk);
		t = time_base;
		repeat (40) @(posedge mclk);
		chk("idle halt", t, time_base);
		cpu_idle <= 1'b0;
		repeat (40) @(posedge mclk);
		chk1("idle resume", 1'b1, time_base !== t);
		wr(IDX_LOW_CTL, 16'h8002);
		cpu_idle <= 1'b1;
		t = time_base;
		repeat (40) @(posedge mclk);
		chk1("idle run", 1'b1, time_base !== t);
		burst    <= 1'b0;
		cpu_idle <= 1'b0;
	endtask
	task automatic s_gate;
		logic [15:0] d;
		logic [31:0] t;
		wr(IDX_LOW_CTL, 16'h0000);
		wr(IDX_LOW_CNT, 16'h0000);
		rd(IDX_IRQ_STAT, d);
		wr(IDX_LOW_CTL, 16'h8040);
		gate_lvl <= 1'b1;
		repeat (10) @(posedge mclk);
		gate_lvl <= 1'b0;
		repeat (8) @(posedge mclk);
		t = time_base;
		repeat (8) @(posedge mclk);
		chk("gate stop", t, time_base);
		chk1("gate kept", 1'b1, t[15:0] != 16'h0000);
		rd(IDX_IRQ_STAT, d);
		chk("gate status", 32'h0001, d);
	endtask
	task automatic s_high;
		logic [15:0] d;
		logic        w, a;
		wr(IDX_LOW_CTL, 16'h0000);
		wr(IDX_LOW_CNT, 16'h0000);
		wr(IDX_HIGH_PER, 16'h0003);
		wr(IDX_HIGH_CNT, 16'h0000);
		wr(IDX_IRQ_MASK, 16'h0002);
		rd(IDX_IRQ_STAT, d);
		wr(IDX_HIGH_CTL, 16'h8000);
		watch(20, 32'h0003_0000, w, a);
		chk1("high wrap", 1'b1, w);
		chk1("adc on high match", 1'b1, a);
		chk1("irq high", 1'b1, irq);
		wr(IDX_HIGH_CTL, 16'h0000);
		rd(IDX_IRQ_STAT, d);
		chk("high status", 32'h0002, d);
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = 32'h0;
		cpu_idle = 1'b0;
		burst = 1'b0;
		gate_lvl = 1'b0;
		capture = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		s_reset;
		s_hold;
		s_wrap16;
		s_cascade;
		s_presc;
		s_ext;
		s_gate;
		s_high;
		test_done;
	end
endmodule
